//--- verilog/cmc_pkg.sv
// Operation
// - listen-only: receive frames, send only recessive, never transmit.
// - listen-only: dominant bits to send loop back inside; bus recessive.
// - module enable low gates all controller clocks off.
// - sleep stops all clocks except those for register access.
// - wake irq only when asleep, wake enabled and wake irq enabled.
// - with cpu running, sleep is the only low-power state.
// - cpu wait with stop-in-wait forces power down; then restart to normal.
// - cpu stop forces power down whatever the sleep and stop-in-wait bits.
// - sleep waits until every transmit buffer is empty again.
// - sleep waits for bus idle when receiving, otherwise enters at once.
// - sleep ack set once asleep; sleep request cannot be cleared before that.
// - bus-off recovery count pauses in sleep, resumes after; tx recessive.
// - in sleep rx full may be cleared but nothing moves into foreground.
// - in sleep transmit flags stay clearable but aborts wait for wake-up.
// - in sleep without wake enable the internal receive line stays recessive.
// - sleep ends on bus activity with wake enable, request cleared, init request or module disable.
// - after wake-up wait for 11 recessive bits before joining the bus.
// - deferred receive moves, aborts and transmissions run after wake-up.
// - init aborts transfers at once, drops sync, forces transmit recessive.
// - init mode resets control and flag registers, opens config writes.
// - init ack follows request after sync delay; request held until then.
// - power down aborts transfers at once and forces transmit recessive.
package cmc_pkg;
    // ****************************************************
    // register offsets
    // ****************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TXE = 8'h08;
    localparam logic [7:0] ADDR_RXF = 8'h0C;
    localparam logic [7:0] ADDR_ABORT = 8'h10;
    localparam logic [7:0] ADDR_WAKE = 8'h14;
    // ****************************************************
    // field positions
    // ****************************************************
    localparam int CTRL_INIT = 0;
    localparam int CTRL_SLEEP = 1;
    localparam int CTRL_WAKE_EN = 2;
    localparam int CTRL_STOP_WAIT = 3;
    localparam int CTRL_WAKE_IRQ_EN = 4;
    localparam int CTRL_LISTEN = 5;
    localparam int CTRL_ENABLE = 7;
    localparam int STAT_INIT_ACK = 0;
    localparam int STAT_SLEEP_ACK = 1;
    localparam int STAT_POWER_DOWN = 2;
    localparam int STAT_SYNCED = 3;
    // ****************************************************
    // reset values and timing
    // ****************************************************
    localparam logic INIT_REQ_RESET = 1'b1;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic TX_EMPTY_RESET = 1'b1;
    localparam int INIT_BUS_CLKS = 2;
    localparam int INIT_CAN_CLKS = 3;
    localparam int INIT_DELAY = INIT_BUS_CLKS + INIT_CAN_CLKS;
    localparam int WAKE_REC_BITS = 11;
    typedef enum logic [1:0] {
        ST_NORMAL = 2'b00,
        ST_SLEEP_PEND = 2'b01,
        ST_ASLEEP = 2'b10,
        ST_RESYNC = 2'b11
    } cmc_state_t;
endpackage

//--- verilog/cmc_mode_ctrl.sv
// Design decisions made here: the address map and register access over AHB-Lite.
`timescale 1ns/100ps
module cmc_mode_ctrl import cmc_pkg::*; #(
    parameter int NUM_TX = 3
) (
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic BUS_RX_PIN,
    output logic BUS_TX_PIN,
    input wire logic CPU_WAIT,
    input wire logic CPU_STOP,
    input wire logic PROTO_TX,
    input wire logic PROTO_TX_BUSY,
    input wire logic PROTO_RX_BUSY,
    input wire logic BUS_IDLE,
    input wire logic BIT_TICK,
    input wire logic RX_BG_VALID,
    input wire logic [NUM_TX-1:0] TX_BUF_DONE,
    output logic CORE_RX,
    output logic CORE_CLK_EN,
    output logic REG_CLK_EN,
    output logic TX_START_EN,
    output logic CORE_ABORT,
    output logic CORE_INIT,
    output logic CONFIG_WR_EN,
    output logic BUSOFF_CNT_EN,
    output logic RX_MOVE,
    output logic [NUM_TX-1:0] TX_SCHEDULED,
    output logic [NUM_TX-1:0] ABORT_REQ,
    output logic WAKE_IRQ
);
    function automatic logic is_reg(input logic [7:0] a, input logic [7:0] o);
        is_reg = (a == o);
    endfunction

    // ****************************************************
    // pin synchronisers
    // ****************************************************
    logic rx_meta, rx_s, wait_meta, wait_s, stop_meta, stop_s;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            rx_meta <= 1'b1;
            rx_s <= 1'b1;
            wait_meta <= 1'b0;
            wait_s <= 1'b0;
            stop_meta <= 1'b0;
            stop_s <= 1'b0;
        end else begin
            rx_meta <= BUS_RX_PIN;
            rx_s <= rx_meta;
            wait_meta <= CPU_WAIT;
            wait_s <= wait_meta;
            stop_meta <= CPU_STOP;
            stop_s <= stop_meta;
        end
    end

    // ****************************************************
    // ahb-lite slave
    // ****************************************************
    logic wr_pend, rd_pend, dp_hi;
    logic [7:0] dp_addr;
    wire addr_ok = HSEL & HREADY & HTRANS[1];
    // reads take one wait state so a write just before is seen
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_addr <= 8'h00;
            dp_hi <= 1'b0;
        end else begin
            wr_pend <= addr_ok & HWRITE;
            rd_pend <= addr_ok & ~HWRITE;
            if (addr_ok) begin
                dp_addr <= HADDR[7:0];
                dp_hi <= (HADDR[31:8] == 24'h000000);
            end
        end
    end
    wire [31:0] wd = HWDATA;
    wire sw_ctrl = wr_pend & dp_hi & is_reg(dp_addr, ADDR_CTRL);
    wire sw_txe = wr_pend & dp_hi & is_reg(dp_addr, ADDR_TXE);
    wire sw_rxf = wr_pend & dp_hi & is_reg(dp_addr, ADDR_RXF);
    wire sw_abort = wr_pend & dp_hi & is_reg(dp_addr, ADDR_ABORT);
    wire sw_wake = wr_pend & dp_hi & is_reg(dp_addr, ADDR_WAKE);

    // ****************************************************
    // control bits and mode decode
    // ****************************************************
    logic module_enable, stop_in_wait, wakeup_enable, wake_irq_en;
    logic listen_only, init_request, sleep_request, init_ack;
    logic [2:0] init_cnt;
    logic [3:0] rec_cnt;
    cmc_state_t state, next_state;
    wire pd = stop_s | (wait_s & stop_in_wait);
    wire in_init = init_request;
    wire init_enter = init_request & (init_cnt == 3'h0);
    wire run = module_enable & ~pd & ~in_init;
    wire awake = run & (state != ST_ASLEEP);
    wire synced = awake & (state != ST_RESYNC);
    wire all_empty;
    wire wake_hit = (state == ST_ASLEEP) & wakeup_enable & ~rx_s;
    wire rec_done = BIT_TICK & rx_s & run &
        (rec_cnt == 4'(WAKE_REC_BITS - 1));
    wire sleep_ok = all_empty & ~PROTO_TX_BUSY &
        (~PROTO_RX_BUSY | BUS_IDLE);

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            module_enable <= ENABLE_RESET;
            init_request <= INIT_REQ_RESET;
            stop_in_wait <= 1'b0;
            wakeup_enable <= 1'b0;
            wake_irq_en <= 1'b0;
            listen_only <= 1'b0;
            sleep_request <= 1'b0;
        end else begin
            if (sw_ctrl) begin
                module_enable <= wd[CTRL_ENABLE];
                stop_in_wait <= wd[CTRL_STOP_WAIT];
                wakeup_enable <= wd[CTRL_WAKE_EN];
                wake_irq_en <= wd[CTRL_WAKE_IRQ_EN];
                if (in_init) begin
                    listen_only <= wd[CTRL_LISTEN];
                end
                if (wd[CTRL_INIT] | init_ack) begin
                    init_request <= wd[CTRL_INIT];
                end
                // a set request may only be withdrawn once asleep
                if (wd[CTRL_SLEEP] | (state == ST_ASLEEP)) begin
                    sleep_request <= wd[CTRL_SLEEP];
                end
            end
            if (wake_hit) begin
                sleep_request <= 1'b0;
            end
            if (init_enter) begin
                sleep_request <= 1'b0;
                wakeup_enable <= 1'b0;
                stop_in_wait <= 1'b0;
                wake_irq_en <= 1'b0;
            end
        end
    end

    // ****************************************************
    // init handshake
    // ****************************************************
    // one clock here stands for both domains; the delay keeps the
    // documented minimum of bus plus can clocks
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            init_cnt <= 3'h0;
            init_ack <= 1'b0;
        end else begin
            if (!init_request) begin
                init_cnt <= 3'h0;
            end else if (init_cnt != 3'(INIT_DELAY)) begin
                init_cnt <= init_cnt + 3'h1;
            end
            init_ack <= init_request & (init_cnt == 3'(INIT_DELAY));
        end
    end

    // ****************************************************
    // sleep state machine
    // ****************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            ST_NORMAL: begin
                if (sleep_request) next_state = ST_SLEEP_PEND;
            end
            ST_SLEEP_PEND: begin
                if (!sleep_request) next_state = ST_NORMAL;
                else if (sleep_ok) next_state = ST_ASLEEP;
            end
            ST_ASLEEP: begin
                if (!sleep_request | wake_hit) next_state = ST_RESYNC;
            end
            ST_RESYNC: begin
                if (rec_done) next_state = ST_NORMAL;
            end
        endcase
        // power down outside sleep means a full restart
        if (~module_enable | in_init | (pd & (state != ST_ASLEEP))) begin
            next_state = ST_RESYNC;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state <= ST_RESYNC;
            rec_cnt <= 4'h0;
        end else begin
            state <= next_state;
            if ((state != ST_RESYNC) | ~run) begin
                rec_cnt <= 4'h0;
            end else if (BIT_TICK) begin
                rec_cnt <= rx_s ? rec_cnt + 4'h1 : 4'h0;
            end
        end
    end

    // ****************************************************
    // buffer flags
    // ****************************************************
    logic [NUM_TX-1:0] tx_empty, abort_req;
    logic rx_full, wake_flag;
    assign all_empty = &tx_empty;
    // foreground load is held off in sleep and done after wake-up
    wire rx_move = RX_BG_VALID & ~rx_full & awake;
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            tx_empty <= {NUM_TX{TX_EMPTY_RESET}};
            abort_req <= '0;
            rx_full <= 1'b0;
            wake_flag <= 1'b0;
        end else if (init_enter) begin
            tx_empty <= {NUM_TX{TX_EMPTY_RESET}};
            abort_req <= '0;
            rx_full <= 1'b0;
            wake_flag <= 1'b0;
        end else begin
            // hardware sets win over same-cycle software clears
            tx_empty <= (tx_empty & ~({NUM_TX{sw_txe}} & wd[NUM_TX-1:0]))
                | TX_BUF_DONE;
            abort_req <= (abort_req | ({NUM_TX{sw_abort}} & wd[NUM_TX-1:0]))
                & ~TX_BUF_DONE;
            rx_full <= (rx_full & ~(sw_rxf & wd[0])) | rx_move;
            wake_flag <= (wake_flag & ~(sw_wake & wd[0])) | wake_hit;
        end
    end

    // ****************************************************
    // outputs
    // ****************************************************
    wire next_tx_pin = (synced & ~listen_only) ?
        PROTO_TX : 1'b1;
    wire next_core_rx = ((state == ST_ASLEEP) & ~wakeup_enable) ?
        1'b1 :
        listen_only ? (rx_s & PROTO_TX) : rx_s;
    wire next_core_clk = module_enable & ~pd &
        (state != ST_ASLEEP);
    wire next_reg_clk = module_enable & ~pd;
    wire next_tx_start = synced & ~listen_only;
    wire next_abort = in_init | pd | ~module_enable;
    wire [NUM_TX-1:0] next_sched = ~tx_empty & {NUM_TX{next_tx_start}};
    wire [NUM_TX-1:0] next_abort_req = abort_req & ~tx_empty &
        {NUM_TX{awake}};
    wire next_irq = wake_flag & wake_irq_en;

    wire [7:0] ctrl_val = (8'(module_enable) << CTRL_ENABLE)
        | (8'(listen_only) << CTRL_LISTEN)
        | (8'(wake_irq_en) << CTRL_WAKE_IRQ_EN)
        | (8'(stop_in_wait) << CTRL_STOP_WAIT)
        | (8'(wakeup_enable) << CTRL_WAKE_EN)
        | (8'(sleep_request) << CTRL_SLEEP)
        | (8'(init_request) << CTRL_INIT);
    wire [7:0] stat_val = (8'(init_ack) << STAT_INIT_ACK)
        | (8'(state == ST_ASLEEP) << STAT_SLEEP_ACK)
        | (8'(pd) << STAT_POWER_DOWN)
        | (8'(synced) << STAT_SYNCED);
    wire [31:0] rdata = !dp_hi ? 32'h00000000 :
        is_reg(dp_addr, ADDR_CTRL) ? {24'h000000, ctrl_val} :
        is_reg(dp_addr, ADDR_STATUS) ? {24'h000000, stat_val} :
        is_reg(dp_addr, ADDR_TXE) ? 32'(tx_empty) :
        is_reg(dp_addr, ADDR_RXF) ? 32'(rx_full) :
        is_reg(dp_addr, ADDR_ABORT) ? 32'(abort_req) :
        is_reg(dp_addr, ADDR_WAKE) ? 32'(wake_flag) : 32'h00000000;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            HRDATA <= 32'h00000000;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else begin
            HREADYOUT <= ~(addr_ok & ~HWRITE);
            HRESP <= 1'b0;
            if (rd_pend) HRDATA <= rdata;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            BUS_TX_PIN <= 1'b1;
            CORE_RX <= 1'b1;
            CORE_CLK_EN <= 1'b0;
            REG_CLK_EN <= 1'b0;
            TX_START_EN <= 1'b0;
            CORE_ABORT <= 1'b1;
            CORE_INIT <= 1'b1;
            CONFIG_WR_EN <= 1'b0;
            BUSOFF_CNT_EN <= 1'b0;
            RX_MOVE <= 1'b0;
            TX_SCHEDULED <= '0;
            ABORT_REQ <= '0;
            WAKE_IRQ <= 1'b0;
        end else begin
            BUS_TX_PIN <= next_tx_pin;
            CORE_RX <= next_core_rx;
            CORE_CLK_EN <= next_core_clk;
            REG_CLK_EN <= next_reg_clk;
            TX_START_EN <= next_tx_start;
            CORE_ABORT <= next_abort;
            CORE_INIT <= in_init;
            CONFIG_WR_EN <= in_init & init_ack;
            BUSOFF_CNT_EN <= awake;
            RX_MOVE <= rx_move;
            TX_SCHEDULED <= next_sched;
            ABORT_REQ <= next_abort_req;
            WAKE_IRQ <= next_irq;
        end
    end

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence s_init_rise;
        $rose(init_request);
    endsequence
    sequence s_wake_done;
        state == ST_RESYNC ##1 state == ST_NORMAL;
    endsequence
    sequence s_leave_sleep;
        state == ST_ASLEEP ##1 state != ST_ASLEEP;
    endsequence

    a_listen_tx_quiet: assert property (
        listen_only |=> BUS_TX_PIN && !TX_START_EN && TX_SCHEDULED == '0)
        else $error("listen-only drove bus or started transmit");
    a_listen_loop_back: assert property (
        listen_only && state != ST_ASLEEP |=>
            CORE_RX == ($past(rx_s) & $past(PROTO_TX)))
        else $error("listen-only loopback wrong");
    a_disable_clocks_off: assert property (
        !module_enable |=> !CORE_CLK_EN && !REG_CLK_EN)
        else $error("clocks running while disabled");
    a_sleep_reg_clock: assert property (
        state == ST_ASLEEP && module_enable && !pd |=>
            !CORE_CLK_EN && REG_CLK_EN)
        else $error("sleep clock gating wrong");
    a_wake_irq_cause: assert property (
        $rose(wake_flag) |-> $past(state == ST_ASLEEP && wakeup_enable))
        else $error("wake flag outside sleep");
    a_wake_irq_gate: assert property (
        WAKE_IRQ |-> $past(wake_flag && wake_irq_en))
        else $error("wake interrupt without enable");
    a_sleep_via_pend: assert property (
        $rose(state == ST_ASLEEP) |-> $past(state) == ST_SLEEP_PEND
            || $past(state) == ST_ASLEEP)
        else $error("sleep entered without request");
    a_pd_restart: assert property (
        pd && state == ST_NORMAL |=> state == ST_RESYNC)
        else $error("power down did not restart");
    a_stop_power_down: assert property (
        stop_s && module_enable |=> !CORE_CLK_EN && BUS_TX_PIN)
        else $error("stop did not power down");
    a_sleep_waits_tx: assert property (
        state == ST_SLEEP_PEND && !all_empty |=> state != ST_ASLEEP)
        else $error("slept with scheduled buffer");
    a_sleep_waits_rx: assert property (
        state == ST_SLEEP_PEND && PROTO_RX_BUSY && !BUS_IDLE |=>
            state != ST_ASLEEP)
        else $error("slept during reception");
    a_sleep_req_held: assert property (
        state == ST_SLEEP_PEND && sleep_request && !init_request |=>
            sleep_request)
        else $error("sleep request cleared early");
    a_busoff_paused: assert property (
        state == ST_ASLEEP |=> !BUSOFF_CNT_EN && BUS_TX_PIN)
        else $error("bus-off counting in sleep");
    a_no_rx_move: assert property (
        state == ST_ASLEEP |=> !RX_MOVE)
        else $error("foreground loaded in sleep");
    a_no_sleep_abort: assert property (
        state == ST_ASLEEP |=> ABORT_REQ == '0)
        else $error("abort carried out in sleep");
    a_rx_masked: assert property (
        state == ST_ASLEEP && !wakeup_enable |=> CORE_RX)
        else $error("receive line not masked");
    a_leave_cause: assert property (
        s_leave_sleep |-> $past(!sleep_request || wake_hit ||
            !module_enable || in_init, 1))
        else $error("sleep left without cause");
    a_resync_bits: assert property (
        s_wake_done |-> $past(rec_cnt) == 4'(WAKE_REC_BITS - 1))
        else $error("joined bus before recessive run");
    a_init_abort_tx: assert property (
        init_request |=> CORE_ABORT && BUS_TX_PIN && !TX_START_EN)
        else $error("init did not abort");
    a_init_ack_late: assert property (
        s_init_rise |-> !init_ack [*6])
        else $error("init ack too early");
    a_init_ack_due: assert property (
        s_init_rise ##6 init_request |-> init_ack)
        else $error("init ack missing");
    a_init_req_held: assert property (
        init_request && !init_ack |=> init_request)
        else $error("init request cleared early");
    a_pd_abort: assert property (
        pd |=> CORE_ABORT && BUS_TX_PIN)
        else $error("power down did not abort");
endmodule // cmc_mode_ctrl

//--- sim/cmc_bus_node.sv
`timescale 1ns/100ps
// ********
// far-side bus node
// ********
module cmc_bus_node (
    input wire logic clock,
    input wire logic tx_pin,
    input wire logic force_dom,
    output logic rx_pin,
    output logic bit_tick
);
    logic [1:0] cnt = 2'h0;
    // wired-and bus with pull-up: a released line reads recessive
    assign rx_pin = tx_pin & ~force_dom;
    assign bit_tick = (cnt == 2'h0);
    always @(posedge clock) begin
        cnt <= cnt + 2'h1;
    end
endmodule // cmc_bus_node

//--- sim/can_controller_mode_control_tb.sv
`timescale 1ns/100ps
// ********
// mode control bench
// ********
module can_controller_mode_control_tb;
    import cmc_pkg::*;
    logic CLOCK = 1'b0, RST = 1'b1, HSEL = 1'b0, HWRITE = 1'b0;
    logic CPU_WAIT = 1'b0, CPU_STOP = 1'b0, PROTO_TX = 1'b1, dom = 1'b0;
    logic PROTO_TX_BUSY = 1'b0, PROTO_RX_BUSY = 1'b0, BUS_IDLE = 1'b1;
    logic RX_BG_VALID = 1'b0, HREADYOUT, HRESP, BUS_TX_PIN, CORE_RX;
    logic CORE_CLK_EN, REG_CLK_EN, TX_START_EN, CORE_ABORT, CORE_INIT;
    logic CONFIG_WR_EN, BUSOFF_CNT_EN, RX_MOVE, WAKE_IRQ, pd;
    logic HREADY, BUS_RX_PIN, BIT_TICK;
    logic [1:0] HTRANS = 2'h0;
    logic [2:0] HSIZE = 3'h2, TX_BUF_DONE = 3'h0, TX_SCHEDULED, ABORT_REQ;
    logic [2:0] wt = 3'h3, st = 3'h4, csw = 3'h1;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, rd;
    logic [31:0] seed = 32'h00011128;
    int num_errors = 0, checked = 0, moves = 0, n, m, i;
    always #5 CLOCK = ~CLOCK;
    assign HREADY = HREADYOUT;
    always @(posedge CLOCK) if (RX_MOVE === 1'b1) moves <= moves + 1;
    cmc_bus_node cmc_bus_node_inst (.clock(CLOCK), .tx_pin(BUS_TX_PIN),
        .force_dom(dom), .rx_pin(BUS_RX_PIN), .bit_tick(BIT_TICK));
    cmc_mode_ctrl #(.NUM_TX(3)) cmc_mode_ctrl_inst (.CLOCK(CLOCK),
        .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY),
        .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
        .BUS_RX_PIN(BUS_RX_PIN), .BUS_TX_PIN(BUS_TX_PIN),
        .CPU_WAIT(CPU_WAIT), .CPU_STOP(CPU_STOP), .PROTO_TX(PROTO_TX),
        .PROTO_TX_BUSY(PROTO_TX_BUSY), .PROTO_RX_BUSY(PROTO_RX_BUSY),
        .BUS_IDLE(BUS_IDLE), .BIT_TICK(BIT_TICK),
        .RX_BG_VALID(RX_BG_VALID), .TX_BUF_DONE(TX_BUF_DONE),
        .CORE_RX(CORE_RX), .CORE_CLK_EN(CORE_CLK_EN),
        .REG_CLK_EN(REG_CLK_EN), .TX_START_EN(TX_START_EN),
        .CORE_ABORT(CORE_ABORT), .CORE_INIT(CORE_INIT),
        .CONFIG_WR_EN(CONFIG_WR_EN), .BUSOFF_CNT_EN(BUSOFF_CNT_EN),
        .RX_MOVE(RX_MOVE), .TX_SCHEDULED(TX_SCHEDULED),
        .ABORT_REQ(ABORT_REQ), .WAKE_IRQ(WAKE_IRQ));
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge CLOCK);
    endtask
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xorshift = t ^ (t << 5);
    endfunction
    // bounded: a stuck slave ends the run instead of hanging it
    task automatic wait_ready();
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (HREADYOUT !== 1'b1 && n < 40);
        if (n >= 40) begin
            num_errors++;
            print_verdict();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        wait_ready();
        HTRANS <= 2'h0;
        HWDATA <= d;
        wait_ready();
        rd = HRDATA;
    endtask
    task automatic poll(input logic [7:0] a, input int b, input logic v,
        input string what);
        int k;
        k = 0;
        do begin
            ahb(1'b0, a, 32'h0);
            k++;
        end while (rd[b] !== v && k < 30);
        chk(what, rd[b], v);
    endtask
    initial begin
        repeat (100000) @(posedge CLOCK);
        num_errors++;
        print_verdict();
    end
    initial begin
        tick(16);
        RST <= 1'b0;
        chk("tx idle", BUS_TX_PIN, 1'b1);
        ahb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", rd, 32'h1);
        poll(ADDR_STATUS, STAT_INIT_ACK, 1'b1, "init ack");
        chk("cfg wr", CONFIG_WR_EN, 1'b1);
        ahb(1'b1, ADDR_CTRL, 32'h81);
        ahb(1'b1, ADDR_CTRL, 32'h80);
        poll(ADDR_STATUS, STAT_INIT_ACK, 1'b0, "init off");
        chk("clk en", CORE_CLK_EN, 1'b1);
        poll(ADDR_STATUS, STAT_SYNCED, 1'b1, "synced");
        ahb(1'b1, ADDR_TXE, 32'h1);
        ahb(1'b0, ADDR_TXE, 32'h0);
        chk("txe", rd, 32'h6);
        chk("sched", TX_SCHEDULED, 3'h1);
        PROTO_RX_BUSY <= 1'b1;
        BUS_IDLE <= 1'b0;
        ahb(1'b1, ADDR_CTRL, 32'h96);
        tick(5);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("ack tx", rd[1], 1'b0);
        TX_BUF_DONE <= 3'h1;
        tick(1);
        TX_BUF_DONE <= 3'h0;
        tick(5);
        ahb(1'b0, ADDR_STATUS, 32'h0);
        chk("ack rx", rd[1], 1'b0);
        BUS_IDLE <= 1'b1;
        poll(ADDR_STATUS, STAT_SLEEP_ACK, 1'b1, "sleep ack");
        chk("core clk", CORE_CLK_EN, 1'b0);
        chk("reg clk", REG_CLK_EN, 1'b1);
        chk("busoff cnt", BUSOFF_CNT_EN, 1'b0);
        chk("tx rec", BUS_TX_PIN, 1'b1);
        m = moves;
        RX_BG_VALID <= 1'b1;
        ahb(1'b1, ADDR_TXE, 32'h2);
        ahb(1'b0, ADDR_TXE, 32'h0);
        chk("txe sleep", rd, 32'h5);
        ahb(1'b1, ADDR_ABORT, 32'h2);
        tick(6);
        chk("moves", moves, m);
        chk("abort", ABORT_REQ, 3'h0);
        dom <= 1'b1;
        tick(8);
        dom <= 1'b0;
        n = 0;
        for (i = 0; i < 300 && TX_START_EN !== 1'b1; i++) begin
            @(posedge CLOCK);
            if (BIT_TICK === 1'b1) n++;
        end
        chk("resync", n >= 11 && n <= 13, 1'b1);
        chk("wake irq", WAKE_IRQ, 1'b1);
        chk("move", moves, m + 1);
        chk("abort", ABORT_REQ, 3'h2);
        chk("sched wake", TX_SCHEDULED, 3'h2);
        RX_BG_VALID <= 1'b0;
        ahb(1'b0, ADDR_CTRL, 32'h0);
        chk("sleep bit", rd[1], 1'b0);
        ahb(1'b1, ADDR_WAKE, 32'h1);
        tick(2);
        chk("irq clr", WAKE_IRQ, 1'b0);
        for (i = 0; i < 3; i++) begin
            pd = st[i] | (wt[i] & csw[i]);
            ahb(1'b1, ADDR_CTRL, 32'h80 | (32'(csw[i]) << 3));
            CPU_WAIT <= wt[i];
            CPU_STOP <= st[i];
            tick(6);
            poll(ADDR_STATUS, STAT_POWER_DOWN, pd, "pd");
            chk("pd tx", BUS_TX_PIN | !pd, 1'b1);
            chk("pd abort", CORE_ABORT | !pd, 1'b1);
            CPU_WAIT <= 1'b0;
            CPU_STOP <= 1'b0;
            poll(ADDR_STATUS, STAT_POWER_DOWN, 1'b0, "pd off");
        end
        ahb(1'b1, ADDR_CTRL, 32'h81);
        tick(2);
        chk("init tx", BUS_TX_PIN, 1'b1);
        chk("init abort", CORE_ABORT, 1'b1);
        chk("init core", CORE_INIT, 1'b1);
        poll(ADDR_STATUS, STAT_INIT_ACK, 1'b1, "init ack");
        ahb(1'b1, ADDR_CTRL, 32'hA1);
        ahb(1'b0, ADDR_CTRL, 32'h0);
        chk("ctrl", rd, 32'hA1);
        ahb(1'b0, ADDR_TXE, 32'h0);
        chk("txe", rd, 32'h7);
        ahb(1'b1, ADDR_CTRL, 32'hA0);
        poll(ADDR_STATUS, STAT_INIT_ACK, 1'b0, "init off");
        for (i = 0; i < 40; i++) begin
            seed = xorshift(seed);
            PROTO_TX <= seed[0];
            @(posedge CLOCK);
            chk("listen tx", BUS_TX_PIN, 1'b1);
            chk("listen start", TX_START_EN, 1'b0);
        end
        PROTO_TX <= 1'b0;
        tick(4);
        chk("loopback", CORE_RX, 1'b0);
        PROTO_TX <= 1'b1;
        ahb(1'b1, ADDR_CTRL, 32'h0);
        tick(3);
        chk("disabled", CORE_CLK_EN, 1'b0);
        ahb(1'b0, 8'h40, 32'h0);
        chk("unmapped", rd, 32'h0);
        print_verdict();
    end
endmodule // can_controller_mode_control_tb
